// ---- pic_host.sv ----
// Purpose: Host controller driving a priority interrupt controller's pins
// Assumes: Software orders transfers over Avalon-MM; device needs no clock
// Notes:   Chain lines and master-select pin stay between devices
//
// How it works
// - Reads and writes happen only while device select is held low.
// - Edge requests rise low-to-high and stay high until acknowledged.
// - Host sends acknowledge pulses; device returns vector bytes on them.
// - Host drives register select from bit 8 of the command word.
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module pic_host
    import pic_host_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output dev_pins_t        dev_out,
    input  wire logic [7:0]  data_in,
    input  wire logic        irq_in
);

    // Synchronised device inputs
    logic [8:0] sync_q;
    logic [7:0] data_s;
    logic       irq_s;

    pin_sync #(.W(9)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({irq_in, data_in}),
        .q        (sync_q)
    );
    assign data_s = sync_q[7:0];
    assign irq_s  = sync_q[8];

    // Bus slave group
    logic        resp_ff;
    logic        nxt_resp;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;

    // Core group
    state_t      state_ff;
    state_t      nxt_state;
    op_t         op_ff;
    op_t         nxt_op;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic [1:0]  idx_ff;
    logic [1:0]  nxt_idx;
    dev_pins_t   pins_ff;
    dev_pins_t   nxt_pins;
    logic [7:0]  wdata_ff;
    logic [7:0]  nxt_wdata;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic [23:0] vector_ff;
    logic [23:0] nxt_vector;
    logic [1:0]  pulses_ff;
    logic [1:0]  nxt_pulses;
    logic        auto_ff;
    logic        nxt_auto;
    logic        badop_ff;
    logic        nxt_badop;
    logic        done_ff;
    logic        nxt_done;

    logic        wr_take;
    logic        cmd_go;
    logic [31:0] wmask;
    logic        busy;

    assign wr_take = write & resp_ff;
    assign cmd_go  = wr_take & (address == CMD_OFS) & byteenable[0]
                     & (op_t'(writedata[1:0]) != OP_NONE);
    assign wmask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                      {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign busy    = (state_ff != ST_IDLE);

    assign waitrequest = (read | write) & ~resp_ff;
    assign readdata    = readdata_ff;
    assign dev_out     = pins_ff;

    // Bus answer one cycle after request
    always_comb begin
        nxt_resp     = (read | write) & ~resp_ff;
        nxt_readdata = readdata_ff;
        if (read & ~resp_ff) begin
            case (address)
                STATUS_OFS: nxt_readdata = {28'h000_0000, done_ff, badop_ff,
                                            irq_s, busy};
                WDATA_OFS:  nxt_readdata = {24'h00_0000, wdata_ff};
                RDATA_OFS:  nxt_readdata = {24'h00_0000, rdata_ff};
                VECTOR_OFS: nxt_readdata = {8'h00, vector_ff};
                CONFIG_OFS: nxt_readdata = {29'h0000_0000, auto_ff, pulses_ff};
                default:    nxt_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            resp_ff     <= 1'b0;
            readdata_ff <= 32'h0000_0000;
        end else begin
            resp_ff     <= nxt_resp;
            readdata_ff <= nxt_readdata;
        end
    end

    // Device sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_op     = op_ff;
        nxt_cnt    = cnt_ff - 4'h1;
        nxt_idx    = idx_ff;
        nxt_pins   = pins_ff;
        nxt_wdata  = wdata_ff;
        nxt_rdata  = rdata_ff;
        nxt_vector = vector_ff;
        nxt_pulses = pulses_ff;
        nxt_auto   = auto_ff;
        nxt_badop  = badop_ff;
        nxt_done   = done_ff;

        if (wr_take && address == WDATA_OFS) begin
            nxt_wdata = (wdata_ff & ~wmask[7:0]) | (writedata[7:0] & wmask[7:0]);
        end
        if (wr_take && address == CONFIG_OFS && byteenable[0]) begin
            nxt_pulses = writedata[1:0];
            nxt_auto   = writedata[CFG_AUTO_BIT];
        end
        if (wr_take && address == STATUS_OFS && byteenable[0]) begin
            nxt_badop = badop_ff & ~writedata[ST_BADOP_BIT];
            nxt_done  = done_ff & ~writedata[ST_DONE_BIT];
        end

        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = cnt_ff;
                if (cmd_go && op_t'(writedata[1:0]) != OP_ACK) begin
                    nxt_op                   = op_t'(writedata[1:0]);
                    nxt_state                = ST_SETUP;
                    nxt_cnt                  = SETUP_CYC;
                    nxt_pins.select_n        = 1'b0;
                    nxt_pins.register_select = writedata[CMD_RS_BIT];
                    nxt_pins.data_oe         = (op_t'(writedata[1:0]) == OP_WRITE);
                    nxt_pins.data_out        = wdata_ff;
                end else if (cmd_go || (auto_ff && irq_s)) begin
                    nxt_op                       = OP_ACK;
                    nxt_state                    = ST_ACK_LO;
                    nxt_cnt                      = STROBE_CYC;
                    nxt_idx                      = 2'h0;
                    nxt_pins.acknowledge_pulse_n = 1'b0;
                end
            end
            ST_SETUP: begin
                if (cnt_ff == 4'h1) begin
                    nxt_state = ST_STROBE;
                    nxt_cnt   = STROBE_CYC;
                    if (op_ff == OP_WRITE) begin
                        nxt_pins.write_n = 1'b0;
                    end else begin
                        nxt_pins.read_n  = 1'b0;
                    end
                end
            end
            ST_STROBE: begin
                if (cnt_ff == 4'h1) begin
                    nxt_state        = ST_RECOVER;
                    nxt_cnt          = RECOVER_CYC;
                    nxt_pins.write_n = 1'b1;
                    nxt_pins.read_n  = 1'b1;
                    if (op_ff == OP_READ) begin
                        nxt_rdata = data_s;
                    end
                end
            end
            ST_RECOVER: begin
                if (cnt_ff == RECOVER_CYC) begin
                    nxt_pins.select_n = 1'b1;
                    nxt_pins.data_oe  = 1'b0;
                end
                if (cnt_ff == 4'h1) begin
                    nxt_state = ST_IDLE;
                    nxt_done  = 1'b1;
                end
            end
            ST_ACK_LO: begin
                if (cnt_ff == 4'h1) begin
                    nxt_state                    = ST_ACK_GAP;
                    nxt_cnt                      = RECOVER_CYC;
                    nxt_pins.acknowledge_pulse_n = 1'b1;
                    nxt_vector[idx_ff*8 +: 8]    = data_s;
                    if (idx_ff == 2'h0 && pulses_ff == PULSES_RST
                        && data_s != CALL_OPCODE) begin
                        nxt_badop = 1'b1;
                    end
                end
            end
            ST_ACK_GAP: begin
                if (cnt_ff == 4'h1) begin
                    if ((idx_ff + 2'h1) < pulses_ff) begin
                        nxt_idx                      = idx_ff + 2'h1;
                        nxt_state                    = ST_ACK_LO;
                        nxt_cnt                      = STROBE_CYC;
                        nxt_pins.acknowledge_pulse_n = 1'b0;
                    end else begin
                        nxt_state = ST_IDLE;
                        nxt_done  = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_pins  = PINS_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff  <= ST_IDLE;
            op_ff     <= OP_NONE;
            cnt_ff    <= 4'h0;
            idx_ff    <= 2'h0;
            pins_ff   <= PINS_RST;
            wdata_ff  <= WDATA_RST;
            rdata_ff  <= 8'h00;
            vector_ff <= 24'h00_0000;
            pulses_ff <= PULSES_RST;
            auto_ff   <= AUTO_RST;
            badop_ff  <= 1'b0;
            done_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            op_ff     <= nxt_op;
            cnt_ff    <= nxt_cnt;
            idx_ff    <= nxt_idx;
            pins_ff   <= nxt_pins;
            wdata_ff  <= nxt_wdata;
            rdata_ff  <= nxt_rdata;
            vector_ff <= nxt_vector;
            pulses_ff <= nxt_pulses;
            auto_ff   <= nxt_auto;
            badop_ff  <= nxt_badop;
            done_ff   <= nxt_done;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_write_pulse;
        !pins_ff.write_n [*5] ##1 pins_ff.write_n;
    endsequence

    sequence s_ack_pulse;
        !pins_ff.acknowledge_pulse_n [*5] ##1 pins_ff.acknowledge_pulse_n;
    endsequence

    a_strobe_needs_select: assert property (
        (!pins_ff.read_n || !pins_ff.write_n) |-> !pins_ff.select_n)
        else $error("strobe low while device not selected");

    a_ack_without_select: assert property (
        !pins_ff.acknowledge_pulse_n |-> pins_ff.select_n
            && pins_ff.read_n && pins_ff.write_n)
        else $error("acknowledge overlaps a select or strobe");

    a_write_pulse_width: assert property (
        $fell(pins_ff.write_n) |-> pins_ff.data_oe ##0 s_write_pulse)
        else $error("write strobe width or data drive wrong");

    a_read_bus_free: assert property (
        !pins_ff.read_n |-> !pins_ff.data_oe && pins_ff.write_n)
        else $error("host drives bus during read");

    a_read_capture: assert property (
        $rose(pins_ff.read_n) |-> rdata_ff == $past(data_s))
        else $error("read byte not captured at strobe end");

    a_ack_pulse_width: assert property (
        $fell(pins_ff.acknowledge_pulse_n) |-> s_ack_pulse)
        else $error("acknowledge pulse width wrong");

    a_opcode_flag: assert property (
        $rose(pins_ff.acknowledge_pulse_n) && $past(idx_ff) == 2'h0
            && pulses_ff == PULSES_RST && $past(data_s) != CALL_OPCODE
            |-> badop_ff)
        else $error("bad call opcode not flagged");

    a_bus_answer: assert property (
        (read || write) && waitrequest |=> (read || write) |-> !waitrequest)
        else $error("bus answer later than one cycle");

    a_select_release: assert property (
        $rose(pins_ff.write_n) |=> pins_ff.select_n && !pins_ff.data_oe)
        else $error("select not released after write");

    a_auto_ack_start: assert property (
        state_ff == ST_IDLE && auto_ff && irq_s && !cmd_go
            |=> !pins_ff.acknowledge_pulse_n)
        else $error("pending interrupt not acknowledged");

endmodule // pic_host

// ---- pic_host_pkg.sv ----
// Purpose: Shared constants and types for the interrupt controller host
// Assumes: core_clk at 25 MHz, Avalon-MM byte addresses, 32-bit data
// Notes:   Device pin timing figures are in ns, cycles derived here
package pic_host_pkg;

    localparam int CLK_NS     = 40;
    localparam int SETUP_NS   = 40;
    localparam int STROBE_NS  = 200;
    localparam int RECOVER_NS = 200;

    localparam logic [3:0] SETUP_CYC   = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STROBE_CYC  = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS + CLK_NS - 1) / CLK_NS);

    // Register byte offsets
    localparam logic [4:0] CMD_OFS    = 5'h00;
    localparam logic [4:0] WDATA_OFS  = 5'h04;
    localparam logic [4:0] STATUS_OFS = 5'h08;
    localparam logic [4:0] RDATA_OFS  = 5'h0C;
    localparam logic [4:0] VECTOR_OFS = 5'h10;
    localparam logic [4:0] CONFIG_OFS = 5'h14;

    // Field positions
    localparam int CMD_RS_BIT     = 8;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_IRQ_BIT     = 1;
    localparam int ST_BADOP_BIT   = 2;
    localparam int ST_DONE_BIT    = 3;
    localparam int CFG_AUTO_BIT   = 2;

    // Reset values
    localparam logic [1:0] PULSES_RST = 2'h3;
    localparam logic       AUTO_RST   = 1'b0;
    localparam logic [7:0] WDATA_RST  = 8'h00;

    // First vector byte expected in 8-bit host format
    localparam logic [7:0] CALL_OPCODE = 8'b1100_1101;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ  = 2'b10,
        OP_ACK   = 2'b11
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETUP   = 3'b001,
        ST_STROBE  = 3'b010,
        ST_RECOVER = 3'b011,
        ST_ACK_LO  = 3'b100,
        ST_ACK_GAP = 3'b101
    } state_t;

    // Pins driven toward the device
    typedef struct packed {
        logic       select_n;
        logic       read_n;
        logic       write_n;
        logic       register_select;
        logic       acknowledge_pulse_n;
        logic       data_oe;
        logic [7:0] data_out;
    } dev_pins_t;

    localparam dev_pins_t PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00};

endpackage

// ---- pin_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous device pins
// Assumes: Each bit is independent
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= d[i];
                    sync_ff <= meta_ff;
                end
            end
            assign q[i] = sync_ff;
        end
    endgenerate
endmodule // pin_sync

// ---- pic_dev_model.sv ----
// Purpose: Behavioural model of the priority interrupt controller pins
// Assumes: Eight-bit host format, three acknowledge pulses per vector
// Notes:   Released bus shows the inverse of its last driven byte
`timescale 1ns/1ps
module pic_dev_model
    import pic_host_pkg::*;
#(
    parameter logic [7:0] VEC_LO = 8'h00,
    parameter logic [7:0] VEC_HI = 8'h00
) (
    input  wire logic       rst,
    input  wire dev_pins_t  pins,
    input  wire logic [7:0] data_lvl,
    input  wire logic       req,
    input  wire logic       bad_first,
    output logic      [7:0] dev_bus,
    output logic            irq
);
    logic [7:0] word_ff [2] = '{8'h00, 8'h00};
    logic [1:0] ack_cnt_ff  = 2'd0;
    logic [7:0] vec_byte;
    logic [7:0] last_val    = 8'h00;
    logic       drive;
    logic       master_select_or_buffer_ctl = 1'b1;
    logic [2:0] chain_id_lines;

    // Lone master: chain lines driven, no slave addressed
    assign chain_id_lines = master_select_or_buffer_ctl ? 3'b000 : 3'b111;

    // Source 0 only, level sensed, masked by bit 0 of the odd word
    assign irq = req & ~word_ff[1][0];

    always_comb begin
        case (ack_cnt_ff)
            2'd0:    vec_byte = bad_first ? 8'h00 : CALL_OPCODE;
            2'd1:    vec_byte = VEC_LO;
            default: vec_byte = VEC_HI;
        endcase
    end

    // Drives only on acknowledge or selected read
    assign drive = !pins.acknowledge_pulse_n || (!pins.select_n && !pins.read_n);
    assign dev_bus = !drive ? ~last_val :
        (!pins.acknowledge_pulse_n ? vec_byte : word_ff[pins.register_select]);

    always @(dev_bus or drive) begin
        if (drive) begin
            last_val = dev_bus;
        end
    end

    always @(posedge pins.write_n or posedge rst) begin
        if (rst) begin
            word_ff[0] <= 8'h00;
            word_ff[1] <= 8'h00;
        end else if (!pins.select_n) begin
            word_ff[pins.register_select] <= data_lvl;
        end
    end

    always @(posedge pins.acknowledge_pulse_n or posedge rst) begin
        if (rst) begin
            ack_cnt_ff <= 2'd0;
        end else begin
            ack_cnt_ff <= (ack_cnt_ff == 2'd2) ? 2'd0 : ack_cnt_ff + 2'd1;
        end
    end
endmodule // pic_dev_model

// ---- pic_host_bench.sv ----
// Purpose: Self-checking bench for the interrupt controller host
// Assumes: Device model answers at once with fixed vector bytes
// Notes:   A monitor counts low cycles of the select, read, write and acknowledge pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module pic_host_bench
    import pic_host_pkg::*;
;
    localparam logic [7:0] VLO = 8'h40;
    localparam logic [7:0] VHI = 8'h12;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata;
    logic        waitrequest;
    dev_pins_t   dev_out;
    logic [7:0]  dev_bus;
    logic [7:0]  wire_lvl;
    logic        irq;
    logic        req = 1'b0;
    logic        bad_first = 1'b0;
    logic [31:0] rv;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          sel_cyc, wr_cyc, rd_cyc, ack_cyc;

    assign wire_lvl = dev_out.data_oe ? dev_out.data_out : dev_bus;

    pic_host uut (
        .core_clk    (core_clk),
        .rst         (rst),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .dev_out     (dev_out),
        .data_in     (wire_lvl),
        .irq_in      (irq)
    );

    pic_dev_model #(.VEC_LO(VLO), .VEC_HI(VHI)) dev (
        .rst       (rst),
        .pins      (dev_out),
        .data_lvl  (wire_lvl),
        .req       (req),
        .bad_first (bad_first),
        .dev_bus   (dev_bus),
        .irq       (irq)
    );

    always #20 core_clk = ~core_clk;

    // Sample settled pins away from the launching edge
    always @(negedge core_clk) begin
        if (!rst) begin
            sel_cyc += int'(!dev_out.select_n);
            wr_cyc  += int'(!dev_out.write_n);
            rd_cyc  += int'(!dev_out.read_n);
            ack_cyc += int'(!dev_out.acknowledge_pulse_n);
            `CHK("strobe_unsel", 1'b0, (!dev_out.read_n || !dev_out.write_n) && dev_out.select_n)
            `CHK("bus_fight", 1'b0, dev_out.data_oe && !dev_out.read_n)
        end
    end

    task automatic end_of_test();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int   n;
        logic wt;
        n = 0;
        wt = 1'b1;
        address <= a;
        writedata <= d;
        if (wr) begin
            write <= 1'b1;
        end else begin
            read <= 1'b1;
        end
        while (wt && n < 20) begin
            @(negedge core_clk);
            wt = (waitrequest !== 1'b0);
            @(posedge core_clk);
            n++;
        end
        if (wt) begin
            mismatches++;
            end_of_test();
        end
        rv = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        bus_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
        while (rv[b] !== v && n < 40) begin
            bus_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
            n++;
        end
        if (n >= 40) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic clr_all();
        bus_xfer(1'b1, STATUS_OFS, 32'h0000_000C);
        sel_cyc = 0;
        wr_cyc = 0;
        rd_cyc = 0;
        ack_cyc = 0;
    endtask

    task automatic t_reset();
        `CHK("pins_idle", PINS_RST, dev_out)
        bus_xfer(1'b0, CONFIG_OFS, 32'h0000_0000);
        `CHK("config_rst", 32'h0000_0003, rv)
        bus_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
        `CHK("status_rst", 32'h0000_0000, rv)
        bus_xfer(1'b1, 5'h18, 32'hFFFF_FFFF);
        bus_xfer(1'b0, 5'h18, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rv)
        $display("t_reset end");
    endtask

    task automatic t_wr_rd();
        logic [7:0] b;
        for (int i = 0; i < 2; i++) begin
            b = i[0] ? 8'h3C : 8'hA5;
            bus_xfer(1'b1, WDATA_OFS, {24'h00_0000, b});
            clr_all();
            bus_xfer(1'b1, CMD_OFS, {23'h00_0000, i[0], 8'h01});
            wait_bit(ST_DONE_BIT, 1'b1);
            `CHK("sel_cycles", 7, sel_cyc)
            `CHK("wr_cycles", 5, wr_cyc)
        end
        for (int i = 0; i < 2; i++) begin
            clr_all();
            bus_xfer(1'b1, CMD_OFS, {23'h00_0000, i[0], 8'h02});
            wait_bit(ST_DONE_BIT, 1'b1);
            `CHK("rd_cycles", 5, rd_cyc)
            bus_xfer(1'b0, RDATA_OFS, 32'h0000_0000);
            `CHK("rdata", {24'h00_0000, i[0] ? 8'h3C : 8'hA5}, rv)
        end
        $display("t_wr_rd end");
    endtask

    task automatic t_ack();
        req <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
        `CHK("irq_seen", 1'b1, rv[ST_IRQ_BIT])
        clr_all();
        bus_xfer(1'b1, CMD_OFS, 32'h0000_0003);
        wait_bit(ST_DONE_BIT, 1'b1);
        `CHK("ack_cycles", 15, ack_cyc)
        `CHK("ack_unsel", 0, sel_cyc)
        `CHK("no_badop", 1'b0, rv[ST_BADOP_BIT])
        bus_xfer(1'b0, VECTOR_OFS, 32'h0000_0000);
        `CHK("vector", {8'h00, VHI, VLO, CALL_OPCODE}, rv)
        clr_all();
        bad_first <= 1'b1;
        bus_xfer(1'b1, CMD_OFS, 32'h0000_0003);
        wait_bit(ST_DONE_BIT, 1'b1);
        `CHK("badop", 1'b1, rv[ST_BADOP_BIT])
        bus_xfer(1'b1, STATUS_OFS, 32'h0000_0004);
        bus_xfer(1'b0, STATUS_OFS, 32'h0000_0000);
        `CHK("badop_clr", 2'b10, rv[3:2])
        bad_first <= 1'b0;
        $display("t_ack end");
    endtask

    task automatic t_auto_busy();
        clr_all();
        bus_xfer(1'b1, CONFIG_OFS, 32'h0000_0007);
        wait_bit(ST_DONE_BIT, 1'b1);
        bus_xfer(1'b1, CONFIG_OFS, 32'h0000_0003);
        wait_bit(ST_BUSY_BIT, 1'b0);
        req <= 1'b0;
        `CHK("auto_ack", 1'b1, ack_cyc >= 15 && ack_cyc % 15 == 0)
        `CHK("auto_unsel", 0, sel_cyc)
        clr_all();
        bus_xfer(1'b1, CMD_OFS, 32'h0000_0001);
        bus_xfer(1'b1, CMD_OFS, 32'h0000_0002);
        wait_bit(ST_DONE_BIT, 1'b1);
        `CHK("busy_wr", 5, wr_cyc)
        `CHK("busy_rd", 0, rd_cyc)
        $display("t_auto_busy end");
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_wr_rd();
        t_ack();
        t_auto_busy();
        end_of_test();
    end
endmodule // pic_host_bench
